/* File: hdl/sslw_pkg.sv */
// Shared constants and types for the synchronous late-write SRAM port
package sslw_pkg;
   localparam int LANE_W   = 9;
   localparam int LANES    = 4;
   localparam int DATA_W   = LANE_W * LANES;
   localparam int ADDR_W   = 17;
   localparam int LOW_W    = 2;
   localparam int UPPER_W  = ADDR_W - LOW_W;
   localparam int DEPTH    = 1 << ADDR_W;
   localparam int BUF_DEPTH = 2;
   // Edges between command edge and write data edge
   localparam int FLOW_WR_LAG = 1;
   localparam int PIPE_WR_LAG = 2;
   localparam logic [LOW_W-1:0] BURST_CNT_RST = 2'h0;
   localparam logic [LOW_W-1:0] BURST_CNT_INC = 2'h1;
   localparam logic [LANES-1:0] LANE_NONE     = 4'h0;

   typedef logic [DATA_W-1:0]  sslw_data_t;
   typedef logic [ADDR_W-1:0]  sslw_addr_t;
   typedef logic [LANES-1:0]   sslw_mask_t;
   typedef logic [LOW_W-1:0]   sslw_low_t;
   typedef logic [UPPER_W-1:0] sslw_upper_t;

   // Burst kind remembered for continue cycles
   typedef enum logic [1:0] {
      SSLW_OP_IDLE,
      SSLW_OP_READ,
      SSLW_OP_WRITE
   } sslw_op_t;
endpackage

/* File: hdl/sslw_if.sv */
// Internal carriers: memory array port and read data stream
`timescale 1ns/1ps
interface sslw_mem_if;
   import sslw_pkg::*;
   logic       we;
   sslw_addr_t waddr;
   sslw_mask_t wmask;
   sslw_data_t wdata;
   logic       re;
   sslw_addr_t raddr;
   sslw_data_t rdata;
   modport ctrl (output we, waddr, wmask, wdata, re, raddr, input rdata);
   modport mem  (input we, waddr, wmask, wdata, re, raddr, output rdata);
endinterface // sslw_mem_if

interface sslw_stream_if;
   import sslw_pkg::*;
   logic       valid;
   logic       ready;
   sslw_data_t data;
   modport src (output valid, data, input ready);
   modport dst (input valid, data, output ready);
endinterface // sslw_stream_if

/* File: hdl/sslw_mem.sv */
// Byte-lane masked storage array with registered read data
`timescale 1ns/1ps
module sslw_mem (
   input  wire logic sys_clk_in,
   sslw_mem_if.mem   port
);
   import sslw_pkg::*;

   sslw_data_t array_q [DEPTH];
   sslw_data_t rdata_q;

   always_ff @(posedge sys_clk_in) begin
      if (port.we) begin
         for (int l = 0; l < LANES; l++) begin
            if (port.wmask[l]) begin
               array_q[port.waddr][l*LANE_W +: LANE_W] <=
                  port.wdata[l*LANE_W +: LANE_W];
            end
         end
      end
      // Old contents on a same-edge collision; no write bypass
      if (port.re) begin
         rdata_q <= array_q[port.raddr];
      end
   end

   assign port.rdata = rdata_q;
endmodule // sslw_mem

/* File: hdl/sslw_buf.sv */
// Two-entry read data buffer with valid/ready on both sides
`timescale 1ns/1ps
module sslw_buf (
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   sslw_stream_if.dst fill,
   sslw_stream_if.src drain
);
   import sslw_pkg::*;

   sslw_data_t slot_q [BUF_DEPTH];
   logic       head_q;
   logic       tail_q;
   logic [1:0] count_q;
   logic       push;
   logic       pop;

   assign fill.ready  = (count_q != 2'h2);
   assign drain.valid = (count_q != 2'h0);
   assign drain.data  = slot_q[head_q];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         slot_q[tail_q] <= fill.data;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         head_q  <= 1'b0;
         tail_q  <= 1'b0;
         count_q <= 2'h0;
      end else begin
         head_q  <= head_q ^ pop;
         tail_q  <= tail_q ^ push;
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // sslw_buf

/* File: hdl/sslw_port.sv */
// Synchronous SRAM port with late write and burst counter
//
// Overview of operation
// R1 - Gated clock edge holds all state
// R2 - Inputs registered except enable, order, sleep
// R3 - Controller loads new address with step low
// R4 - Selected only when all three selects active
// R5 - Select one low-active, select two high-active
// R6 - Read begins: gate, selects, write high, load
// R7 - Write begins: selected, gate, write strobe low
// R8 - Lane enables pick written lanes independently
// R9 - Write without lane enables is no-op
// R10 - Pipeline read data after output register
// R11 - Pipeline write data at third edge
// R12 - Flow-through read data without output register
// R13 - Flow-through write data at second edge
// R14 - Reads and writes back to back
// R15 - Flow select low picks flow-through timing
// R16 - Step high advances burst counter address
// R17 - Low address bits preset burst counter
// R18 - Linear order low selects linear burst
// R19 - Sleep ignores commands, floats data
// R20 - Output enable high turns drivers off
// R21 - Burst counter wraps after four addresses
// R22 - Order high gives interleaved burst sequence
// R23 - Drivers off during write data cycles
// R24 - Data pins idle unless delivering reads
`timescale 1ns/1ps
module sslw_port (
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  clk_gate_n_in,
   input  wire logic                  chip_sel_1_n_in,
   input  wire logic                  chip_sel_2_in,
   input  wire logic                  chip_sel_3_n_in,
   input  wire logic                  write_n_in,
   input  wire logic                  burst_step_load_in,
   input  wire sslw_pkg::sslw_mask_t  lane_write_n_in,
   input  wire sslw_pkg::sslw_low_t   low_addr_preset_in,
   input  wire sslw_pkg::sslw_upper_t upper_addr_bits_in,
   input  wire sslw_pkg::sslw_data_t  data_lanes_in,
   output wire sslw_pkg::sslw_data_t  data_lanes_out,
   output wire logic                  data_lanes_oe_out,
   input  wire logic                  out_en_n_in,
   input  wire logic                  sleep_req_in,
   input  wire logic                  flow_mode_sel_n_in,
   input  wire logic                  linear_order_n_in,
   output wire logic                  sleeping_out
);
   import sslw_pkg::*;

   // Burst address low bits for a given start and count
   function automatic sslw_low_t burst_low(input sslw_low_t start,
                                           input sslw_low_t count,
                                           input logic      linear_n);
      // R22 interleaved sequence
      if (linear_n) begin
         return start ^ count;
      end
      // R18 linear sequence
      return start + count;
   endfunction

   sslw_mem_if    mem_bus ();
   sslw_stream_if rd_fill ();
   sslw_stream_if rd_drain ();

   // Burst and command state
   sslw_op_t    op_q;
   sslw_low_t   base_q;
   sslw_low_t   cnt_q;
   sslw_upper_t upper_q;
   // Read and write pipelines
   logic        rd_v_q;
   logic        w1_v_q;
   sslw_addr_t  w1_a_q;
   sslw_mask_t  w1_m_q;
   logic        w2_v_q;
   sslw_addr_t  w2_a_q;
   sslw_mask_t  w2_m_q;

   sslw_op_t    op_d;
   sslw_low_t   base_d;
   sslw_low_t   cnt_d;
   sslw_upper_t upper_d;
   logic        rd_v_d;
   logic        w1_v_d;
   sslw_addr_t  w1_a_d;
   sslw_mask_t  w1_m_d;
   logic        w2_v_d;
   sslw_addr_t  w2_a_d;
   sslw_mask_t  w2_m_d;

   wire logic       flow_mode;
   wire logic       step;
   wire logic       cmd_ok;
   wire logic       selected;
   wire logic       load;
   wire logic       begin_rd;
   wire logic       begin_wr;
   wire logic       cont_rd;
   wire logic       cont_wr;
   wire logic       is_rd;
   wire logic       is_wr;
   wire sslw_low_t  cnt_next;
   wire sslw_addr_t eff_addr;
   wire sslw_mask_t lane_mask;
   wire logic       wr_now;
   wire logic       rd_out_v;

   // R15 flow select low means flow-through
   assign flow_mode = ~flow_mode_sel_n_in;
   // R1 gated edge: nothing advances
   assign step      = ~clk_gate_n_in;
   // R19 sleep ignores commands; buffer full also refuses
   assign cmd_ok    = step & ~sleep_req_in & rd_fill.ready;

   // R4 all three selects must be active
   // R5 polarity of each select
   assign selected  = ~chip_sel_1_n_in & chip_sel_2_in & ~chip_sel_3_n_in;
   // R3 load a fresh external address with step low
   assign load      = ~burst_step_load_in;
   // R6 read begins with write strobe high
   assign begin_rd  = cmd_ok & load & selected & write_n_in;
   // R7 write begins with write strobe low
   assign begin_wr  = cmd_ok & load & selected & ~write_n_in;
   // R16 continue cycles follow the burst kind
   assign cont_rd   = cmd_ok & burst_step_load_in & (op_q == SSLW_OP_READ);
   assign cont_wr   = cmd_ok & burst_step_load_in & (op_q == SSLW_OP_WRITE);
   assign is_rd     = begin_rd | cont_rd;
   assign is_wr     = begin_wr | cont_wr;

   // R21 two-bit count wraps after four addresses
   assign cnt_next  = cnt_q + BURST_CNT_INC;
   // R16 counter address on continue cycles
   // R17 low address bits are the counter preset
   assign eff_addr  = load ? {upper_addr_bits_in, low_addr_preset_in}
                           : {upper_q, burst_low(base_q, cnt_next,
                                                 linear_order_n_in)};
   // R8 each lane enable is independent, ignored on reads
   assign lane_mask = ~lane_write_n_in;

   // Burst counter and command kind
   always_comb begin
      op_d    = op_q;
      base_d  = base_q;
      cnt_d   = cnt_q;
      upper_d = upper_q;
      if (step & sleep_req_in) begin
         op_d = SSLW_OP_IDLE;
      end else if (cmd_ok & load) begin
         // R17 preset on load
         base_d  = low_addr_preset_in;
         cnt_d   = BURST_CNT_RST;
         upper_d = upper_addr_bits_in;
         op_d    = begin_rd ? SSLW_OP_READ :
                   begin_wr ? SSLW_OP_WRITE : SSLW_OP_IDLE;
      end else if (cmd_ok) begin
         // R16 advance
         cnt_d = cnt_next;
      end
   end

   // Write address and mask pipeline, one stage per active edge
   always_comb begin
      rd_v_d = rd_v_q;
      w1_v_d = w1_v_q;
      w1_a_d = w1_a_q;
      w1_m_d = w1_m_q;
      w2_v_d = w2_v_q;
      w2_a_d = w2_a_q;
      w2_m_d = w2_m_q;
      if (step) begin
         // R14 a new command each edge, no dead cycle
         rd_v_d = is_rd;
         w1_v_d = is_wr;
         w1_a_d = eff_addr;
         w1_m_d = lane_mask;
         w2_v_d = w1_v_q;
         w2_a_d = w1_a_q;
         w2_m_d = w1_m_q;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         op_q    <= SSLW_OP_IDLE;
         base_q  <= BURST_CNT_RST;
         cnt_q   <= BURST_CNT_RST;
         upper_q <= '0;
      end else begin
         op_q    <= op_d;
         base_q  <= base_d;
         cnt_q   <= cnt_d;
         upper_q <= upper_d;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_v_q <= 1'b0;
         w1_v_q <= 1'b0;
         w1_a_q <= '0;
         w1_m_q <= LANE_NONE;
         w2_v_q <= 1'b0;
         w2_a_q <= '0;
         w2_m_q <= LANE_NONE;
      end else begin
         rd_v_q <= rd_v_d;
         w1_v_q <= w1_v_d;
         w1_a_q <= w1_a_d;
         w1_m_q <= w1_m_d;
         w2_v_q <= w2_v_d;
         w2_a_q <= w2_a_d;
         w2_m_q <= w2_m_d;
      end
   end

   // R13 flow-through takes data one edge after command
   // R11 pipeline takes data two edges after command
   assign wr_now         = step & (flow_mode ? w1_v_q : w2_v_q);
   // R9 empty mask leaves the array untouched
   assign mem_bus.we     = wr_now & ((flow_mode ? w1_m_q : w2_m_q)
                                     != LANE_NONE);
   assign mem_bus.waddr  = flow_mode ? w1_a_q : w2_a_q;
   // R8 lane mask per 9-bit lane
   assign mem_bus.wmask  = flow_mode ? w1_m_q : w2_m_q;
   assign mem_bus.wdata  = data_lanes_in;
   // R2 address and control captured at the command edge
   assign mem_bus.re     = is_rd;
   assign mem_bus.raddr  = eff_addr;

   sslw_mem u_mem (
      .sys_clk_in (sys_clk_in),
      .port       (mem_bus.mem)
   );

   // R10 output register stage, which is the buffer head
   assign rd_fill.valid  = rd_v_q & ~flow_mode & step;
   assign rd_fill.data   = mem_bus.rdata;
   // R1 a held edge keeps the word on the pins
   assign rd_drain.ready = step;

   sslw_buf u_buf (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .fill       (rd_fill.dst),
      .drain      (rd_drain.src)
   );

   // R12 flow-through drives the array register directly
   assign rd_out_v       = flow_mode ? rd_v_q : rd_drain.valid;
   assign data_lanes_out = flow_mode ? mem_bus.rdata
                                     : rd_drain.data;
   // R20 output enable overrides the read pipeline
   // R23 write data cycles never carry read data, so drivers off
   // R24 drive only while read data is due
   // R19 sleep floats the pins
   assign data_lanes_oe_out = rd_out_v & ~out_en_n_in & ~sleep_req_in;
   assign sleeping_out      = sleep_req_in;
endmodule // sslw_port

/* File: tb/sslw_port_props.sv */
// Port timing assertions for the SRAM port
`timescale 1ns/1ps
module sslw_port_props (
   input wire logic                 sys_clk_in,
   input wire logic                 rst_in,
   input wire logic                 clk_gate_n_in,
   input wire logic                 chip_sel_1_n_in,
   input wire logic                 chip_sel_2_in,
   input wire logic                 chip_sel_3_n_in,
   input wire logic                 write_n_in,
   input wire logic                 burst_step_load_in,
   input wire sslw_pkg::sslw_data_t data_lanes_out,
   input wire logic                 data_lanes_oe_out,
   input wire logic                 out_en_n_in,
   input wire logic                 sleep_req_in,
   input wire logic                 flow_mode_sel_n_in,
   input wire logic                 sleeping_out
);
   import sslw_pkg::*;
   wire logic sel;
   wire logic act;
   wire logic rdb;
   wire logic nrd;
   wire logic quiet;
   wire logic oe;
   assign sel = !chip_sel_1_n_in && chip_sel_2_in && !chip_sel_3_n_in;
   assign act = !clk_gate_n_in && !sleep_req_in;
   assign rdb = act && sel && write_n_in && !burst_step_load_in;
   assign nrd = act && !burst_step_load_in && (!sel || !write_n_in);
   assign quiet = !out_en_n_in && !sleep_req_in;
   assign oe = data_lanes_oe_out;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   sequence pipe_rd;
      flow_mode_sel_n_in && rdb ##1 act;
   endsequence
   sequence pipe_gap;
      flow_mode_sel_n_in && nrd ##1 rdb;
   endsequence
   AST_FLOW_RD:
      assert property (!flow_mode_sel_n_in && rdb |=> !quiet || oe)
      else $error("flow read not driven");
   AST_PIPE_RD:
      assert property (pipe_rd |=> !quiet || oe)
      else $error("pipeline read not driven");
   AST_PIPE_LATE:
      assert property (pipe_gap |=> !oe)
      else $error("pipeline read too early");
   AST_PIPE_ONE:
      assert property (pipe_rd ##0 nrd ##1 act |=> !oe)
      else $error("pipeline read held too long");
   AST_FLOW_QUIET:
      assert property (!flow_mode_sel_n_in && nrd |=> !oe)
      else $error("driving without a read");
   AST_GATE_HOLD:
      assert property (clk_gate_n_in && quiet ##1 quiet |->
         $stable(oe) && (!oe || $stable(data_lanes_out)))
      else $error("gated edge changed output");
   AST_OE_OFF:
      assert property (out_en_n_in |-> !oe)
      else $error("driving with enable off");
   AST_SLEEP:
      assert property (sleeping_out == sleep_req_in && !(sleep_req_in && oe))
      else $error("sleep not honoured");
endmodule // sslw_port_props

bind sslw_port sslw_port_props sslw_port_props_inst (.*);

/* File: tb/sslw_ctrl_model.sv */
// Controller side model: late write data delivery
`timescale 1ns/1ps
module sslw_ctrl_model (
   input  wire logic                 sys_clk_in,
   input  wire logic                 clk_gate_n_in,
   input  wire logic                 flow_mode_sel_n_in,
   input  wire logic                 wr_in,
   input  wire sslw_pkg::sslw_data_t wdata_in,
   output sslw_pkg::sslw_data_t      data_out
);
   import sslw_pkg::*;
   sslw_data_t lag1_q = '0;
   sslw_data_t lag2_q = '0;
   // data shifts on active edges only
   always @(posedge sys_clk_in) begin
      if (!clk_gate_n_in) begin
         // Idle bus toggles so stale data never looks valid
         lag1_q <= wr_in ? wdata_in : ~lag1_q;
         lag2_q <= lag1_q;
      end
   end
   // one edge late in flow, two in pipeline
   always @(negedge sys_clk_in) begin
      data_out <= flow_mode_sel_n_in ? lag2_q : lag1_q;
   end
endmodule // sslw_ctrl_model

/* File: tb/test_sslw_port.sv */
// Self-checking bench for the synchronous SRAM port
`timescale 1ns/1ps
module test_sslw_port;
   import sslw_pkg::*;
   logic       clk = 1'h0, rst = 1'h1, gate_n = 1'h0, cs1_n = 1'h1;
   logic       cs2 = 1'h0, cs3_n = 1'h1, wr_n = 1'h1, step = 1'h0;
   logic       oe_n = 1'h0, sleep = 1'h0, flow_n = 1'h0, lin_n = 1'h0;
   logic       wr = 1'h0, ev = 1'h0, pv = 1'h0, oe, slp;
   sslw_mask_t mask = 4'hF;
   logic [5:0] idx = 6'h00, a = 6'h00;
   sslw_data_t wd = '0, ed = '0, pd = '0, din, dout;
   sslw_data_t ref_q [64];
   int         op = 0, k = 0, failures = 0, checked = 0;

   always #4 clk = ~clk;

   sslw_port sslw_port_inst (
      .sys_clk_in(clk), .rst_in(rst), .clk_gate_n_in(gate_n),
      .chip_sel_1_n_in(cs1_n), .chip_sel_2_in(cs2),
      .chip_sel_3_n_in(cs3_n), .write_n_in(wr_n),
      .burst_step_load_in(step), .lane_write_n_in(mask),
      .low_addr_preset_in(idx[1:0]),
      .upper_addr_bits_in(sslw_upper_t'(idx[5:2])),
      .data_lanes_in(din), .data_lanes_out(dout),
      .data_lanes_oe_out(oe), .out_en_n_in(oe_n),
      .sleep_req_in(sleep), .flow_mode_sel_n_in(flow_n),
      .linear_order_n_in(lin_n), .sleeping_out(slp));

   sslw_ctrl_model sslw_ctrl_model_inst (
      .sys_clk_in(clk), .clk_gate_n_in(gate_n),
      .flow_mode_sel_n_in(flow_n), .wr_in(wr), .wdata_in(wd),
      .data_out(din));

   task automatic wrap_up;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input sslw_data_t seen, input sslw_data_t exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   function automatic logic [5:0] baddr(logic [5:0] s, logic [1:0] n);
      return {s[5:2], lin_n ? s[1:0] ^ n : s[1:0] + n};
   endfunction

   function automatic logic rg();
      return $urandom % 8 == 0;
   endfunction

   task automatic cyc(input logic g, s, w, st, input logic [5:0] i,
                      input sslw_mask_t m);
      int         r;
      logic [5:0] ba;
      @(negedge clk);
      chk(sslw_data_t'(oe), sslw_data_t'(ev & !oe_n & !sleep));
      if (ev && !oe_n && !sleep) chk(dout, ed);
      r = $urandom % 3;
      gate_n = g;
      cs1_n = !s && r == 0;
      cs2 = s || r != 1;
      cs3_n = !s && r == 2;
      wr_n = !w;
      step = st;
      mask = m;
      idx = i;
      wd = sslw_data_t'({$urandom, $urandom});
      oe_n = $urandom % 8 == 0;
      if (sleep) begin
         op = 0;
         pv = 1'h0;
         ev = 1'h0;
         wr = 1'h0;
      end else if (!g) begin
         // load on step low, continue on step high
         if (!st) begin
            op = s ? (w ? 2 : 1) : 0;
            a = i;
            k = 0;
         end else if (op != 0) begin
            k++;
         end
         ba = baddr(a, 2'(k));
         wr = op == 2;
         ev = flow_n ? pv : op == 1;
         ed = flow_n ? pd : ref_q[ba];
         pv = op == 1;
         pd = ref_q[ba];
         for (int l = 0; l < LANES; l++) begin
            if (wr && !m[l]) begin
               ref_q[ba][l*LANE_W +: LANE_W] = wd[l*LANE_W +: LANE_W];
            end
         end
      end
   endtask

   task automatic idle(input int n);
      repeat (n) cyc(1'h0, 1'h0, 1'h0, 1'h0, 6'h00, 4'hF);
   endtask

   initial begin
      logic w;
      void'($urandom(91833));
      for (int c = 0; c < 4; c++) begin
         flow_n = c[0];
         lin_n = c[1];
         rst = 1'h1;
         op = 0;
         pv = 1'h0;
         ev = 1'h0;
         repeat (5) @(negedge clk);
         rst = 1'h0;
         for (int i = 0; i < 64; i++) cyc(1'h0, 1'h1, 1'h1, 1'h0, 6'(i), 4'h0);
         idle(3);
         // Commands while asleep must leave memory alone
         sleep = 1'h1;
         cyc(1'h0, 1'h1, 1'h1, 1'h0, 6'h05, 4'h0);
         cyc(1'h0, 1'h1, 1'h0, 1'h0, 6'h05, 4'hF);
         idle(1);
         sleep = 1'h0;
         cyc(1'h0, 1'h1, 1'h0, 1'h0, 6'h05, 4'hF);
         // Reads from one half, writes to the other, back to back
         repeat (150) begin
            w = $urandom % 2;
            cyc(rg(), $urandom % 8 != 0, w, $urandom % 4 == 0,
                {w, 5'($urandom)}, 4'($urandom));
         end
         idle(3);
         for (int i = 32; i < 64; i++) begin
            cyc(rg(), 1'h1, 1'h0, $urandom % 3 == 0, 6'(i), 4'($urandom));
         end
         idle(2);
      end
      wrap_up();
   end

   initial begin
      #200000;
      failures++;
      wrap_up();
   end
endmodule // test_sslw_port
